/* File: rtl/obs_pkg.sv */
package obs_pkg;

	// register file location of the option byte 1 shadow
	localparam logic [11:0] SHADOW_ADDR        = 12'hd0f;
	// stored option byte 1 location in the information block
	localparam logic [7:0]  STORED_OPTION_BYTE1_STORED_ADDR   = 8'hff;

	// field positions inside the shadow byte
	localparam int          FULL_PROT_BIT      = 0;
	localparam int          LOWER_PROT_BIT     = 1;
	localparam int          NO_DIVIDE_BIT      = 2;
	localparam int          STACK_SEL_BIT      = 3;

	// stop-recovery control bits that this block looks at
	localparam int          SMR_DIV_BIT        = 0;
	localparam int          SMR_LOAD_BIT       = 5;

	// values held from reset until the stored byte is loaded
	localparam logic        NO_DIVIDE_RST      = 1'b1;
	localparam logic        STACK_SEL_RST      = 1'b1;
	localparam logic        PROT_RST           = 1'b0;

	// latency of the information block read port, in cycles
	localparam int          INFO_RD_LAT        = 1;

	// programming interface operations
	typedef enum logic [1:0] {
		OBS_OP_READ  = 2'b00,
		OBS_OP_WRITE = 2'b01,
		OBS_OP_ERASE = 2'b10
	} obs_op_t;

	// programming interface targets
	typedef enum logic [1:0] {
		OBS_TGT_MAIN  = 2'b00,
		OBS_TGT_PAGE3 = 2'b01,
		OBS_TGT_OTHER = 2'b10
	} obs_target_t;

	// load sequencer states
	typedef enum logic [1:0] {
		OBS_IDLE    = 2'b00,
		OBS_FETCH   = 2'b01,
		OBS_CAPTURE = 2'b10
	} obs_state_t;

	// decide whether one programming access may go ahead
	function automatic logic obs_allows(
		input obs_op_t     op,
		input obs_target_t tgt,
		input logic        lower_prot,
		input logic        full_prot,
		input logic        addr_upper
	);
		logic open_all;
		open_all = lower_prot & full_prot;
		unique case (tgt)
			OBS_TGT_MAIN:  obs_allows = full_prot & (lower_prot | addr_upper);
			OBS_TGT_PAGE3: obs_allows = (op == OBS_OP_READ) | open_all;
			default:       obs_allows = 1'b1;
		endcase
	endfunction : obs_allows

endpackage : obs_pkg

/* File: rtl/obs_gate_if.sv */
`timescale 1ns/1ps
// protection levels handed from the shadow register to the access gates
interface obs_gate_if;
	logic lower_half_protect;
	logic full_main_protect;

	modport ctrl (output lower_half_protect, output full_main_protect);
	modport gate (input lower_half_protect, input full_main_protect);
endinterface : obs_gate_if

/* File: rtl/obs_access_gate.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// protection gate for one programming interface
module obs_access_gate (
	// protection levels
	obs_gate_if.gate          prot,
	// request from the programming interface
	input  wire logic         req_in,
	input  wire logic [1:0]   op_in,
	input  wire logic [1:0]   target_in,
	input  wire logic         addr_upper_in,
	// answer to the programming interface
	output logic              grant_out,
	output logic              drop_out
);

	wire logic allow_w;

	// evaluated on every access from the live shadow bits, so a mass
	// erase opens the flash at once without another reset
	assign allow_w   = obs_pkg::obs_allows(obs_pkg::obs_op_t'(op_in),
		obs_pkg::obs_target_t'(target_in), prot.lower_half_protect,
		prot.full_main_protect, addr_upper_in);
	assign grant_out = req_in & allow_w;
	// blocked accesses are simply dropped, nothing reaches the array
	assign drop_out  = req_in & ~allow_w;

endmodule : obs_access_gate

/* File: rtl/obs_option_shadow.sv */
`timescale 1ns/1ps
module obs_option_shadow #(
	parameter int MAIN_AW = 14
) (
	// clock and reset
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	// reset controller: pulses in the last cycles of a reset period
	input  wire logic               por_load_in,
	input  wire logic               smr_load_in,
	input  wire logic [7:0]         smr_ctrl_in,
	// information block read port
	output logic [7:0]              info_addr_out,
	output logic                    info_rd_out,
	input  wire logic [7:0]         info_rdata_in,
	// cpu register file access
	input  wire logic [11:0]        reg_addr_in,
	input  wire logic               reg_wr_in,
	input  wire logic               reg_rd_in,
	input  wire logic [7:0]         reg_wdata_in,
	output logic [7:0]              reg_rdata_out,
	output logic                    reg_rvalid_out,
	// flash controller event
	input  wire logic               mass_erase_done_in,
	// in-circuit programming port requests
	input  wire logic               icp_req_in,
	input  wire logic [1:0]         icp_op_in,
	input  wire logic [1:0]         icp_target_in,
	input  wire logic [MAIN_AW-1:0] icp_addr_in,
	output logic                    icp_grant_out,
	output logic                    icp_drop_out,
	// byte programming interface requests
	input  wire logic               bp_req_in,
	input  wire logic [1:0]         bp_op_in,
	input  wire logic [1:0]         bp_target_in,
	input  wire logic [MAIN_AW-1:0] bp_addr_in,
	output logic                    bp_grant_out,
	output logic                    bp_drop_out,
	// system clock enable and stack control
	output logic                    sysclk_en_out,
	output logic                    stack_8bit_out,
	input  wire logic [15:0]        sp_in,
	output logic [15:0]             sp_eff_out
);

	////////////////////////////////////////////////////////////////////
	// state

	obs_pkg::obs_state_t state_reg;
	obs_pkg::obs_state_t state_next;
	logic                stack_sel_reg;
	logic                no_divide_reg;
	logic                lower_prot_reg;
	logic                full_prot_reg;
	logic [7:0]          rdata_reg;
	logic                rvalid_reg;
	logic                div_phase_reg;
	logic                sysclk_en_reg;
	logic [15:0]         sp_eff_reg;

	////////////////////////////////////////////////////////////////////
	// decode

	wire logic       load_req_w;
	wire logic       capture_w;
	wire logic       reg_hit_w;
	wire logic       cpu_wr_w;
	wire logic [7:0] shadow_w;
	wire logic       halve_clk_w;
	wire logic       sysclk_en_next;

	// stop-recovery reset only reloads when its bit 5 is set
	assign load_req_w = por_load_in |
		(smr_load_in & smr_ctrl_in[obs_pkg::SMR_LOAD_BIT]);
	assign capture_w  = (state_reg == obs_pkg::OBS_CAPTURE);
	assign reg_hit_w  = (reg_addr_in == obs_pkg::SHADOW_ADDR);
	assign cpu_wr_w   = reg_wr_in & reg_hit_w;

	// reserved field reads back as zero whatever was written
	assign shadow_w   = {4'h0, stack_sel_reg, no_divide_reg,
		lower_prot_reg, full_prot_reg};

	// divide by two only when the stop-recovery divider is not in use
	assign halve_clk_w    = ~smr_ctrl_in[obs_pkg::SMR_DIV_BIT] &
		no_divide_reg;
	assign sysclk_en_next = halve_clk_w ? ~div_phase_reg : 1'b1;

	////////////////////////////////////////////////////////////////////
	// load sequencer: address the stored byte, then capture it

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			obs_pkg::OBS_IDLE: begin
				if (load_req_w) begin
					state_next = obs_pkg::OBS_FETCH;
				end
			end
			obs_pkg::OBS_FETCH: begin
				state_next = obs_pkg::OBS_CAPTURE;
			end
			obs_pkg::OBS_CAPTURE: begin
				state_next = obs_pkg::OBS_IDLE;
			end
			default: begin
				state_next = obs_pkg::OBS_IDLE;
			end
		endcase
	end

	// the stored byte is fixed at FFh, so the address never changes
	assign info_addr_out = obs_pkg::STORED_OPTION_BYTE1_STORED_ADDR;
	assign info_rd_out   = (state_reg == obs_pkg::OBS_FETCH);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= obs_pkg::OBS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// cpu-writable fields: stack select and no-divide

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stack_sel_reg <= obs_pkg::STACK_SEL_RST;
			no_divide_reg <= obs_pkg::NO_DIVIDE_RST;
		end else if (capture_w) begin
			stack_sel_reg <= info_rdata_in[obs_pkg::STACK_SEL_BIT];
			no_divide_reg <= info_rdata_in[obs_pkg::NO_DIVIDE_BIT];
		end else if (cpu_wr_w) begin
			stack_sel_reg <= reg_wdata_in[obs_pkg::STACK_SEL_BIT];
			no_divide_reg <= reg_wdata_in[obs_pkg::NO_DIVIDE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// protection flip-flops: loaded from flash, opened by mass erase,
	// never written by the cpu

	// mass erase wins over a load in the same cycle so an erase that
	// completes in the capture cycle of a load is not lost
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			lower_prot_reg <= obs_pkg::PROT_RST;
			full_prot_reg  <= obs_pkg::PROT_RST;
		end else if (mass_erase_done_in) begin
			lower_prot_reg <= 1'b1;
			full_prot_reg  <= 1'b1;
		end else if (capture_w) begin
			lower_prot_reg <= info_rdata_in[obs_pkg::LOWER_PROT_BIT];
			full_prot_reg  <= info_rdata_in[obs_pkg::FULL_PROT_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// cpu read port, one cycle of latency

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= reg_rd_in & reg_hit_w;
			rdata_reg  <= (reg_rd_in & reg_hit_w) ? shadow_w : 8'h00;
		end
	end

	assign reg_rdata_out  = rdata_reg;
	assign reg_rvalid_out = rvalid_reg;

	////////////////////////////////////////////////////////////////////
	// system clock enable: every cycle, or every second cycle

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			div_phase_reg <= 1'b0;
			sysclk_en_reg <= 1'b0;
		end else begin
			div_phase_reg <= halve_clk_w ? ~div_phase_reg : 1'b0;
			sysclk_en_reg <= sysclk_en_next;
		end
	end

	assign sysclk_en_out = sysclk_en_reg;

	////////////////////////////////////////////////////////////////////
	// stack pointer width: the high byte is forced to bank 0 when narrow

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sp_eff_reg <= 16'h0000;
		end else if (stack_sel_reg) begin
			sp_eff_reg <= {8'h00, sp_in[7:0]};
		end else begin
			sp_eff_reg <= sp_in;
		end
	end

	assign stack_8bit_out = stack_sel_reg;
	assign sp_eff_out     = sp_eff_reg;

	////////////////////////////////////////////////////////////////////
	// access gates for the two programming interfaces

	obs_gate_if prot_if ();

	assign prot_if.lower_half_protect = lower_prot_reg;
	assign prot_if.full_main_protect  = full_prot_reg;

	// the top address bit tells the lower half of main flash apart
	obs_access_gate u_icp_gate (
		.prot          (prot_if),
		.req_in        (icp_req_in),
		.op_in         (icp_op_in),
		.target_in     (icp_target_in),
		.addr_upper_in (icp_addr_in[MAIN_AW-1]),
		.grant_out     (icp_grant_out),
		.drop_out      (icp_drop_out)
	);

	obs_access_gate u_bp_gate (
		.prot          (prot_if),
		.req_in        (bp_req_in),
		.op_in         (bp_op_in),
		.target_in     (bp_target_in),
		.addr_upper_in (bp_addr_in[MAIN_AW-1]),
		.grant_out     (bp_grant_out),
		.drop_out      (bp_drop_out)
	);

endmodule : obs_option_shadow

/* File: test/obs_option_shadow_monitor.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// port-level checker for the option byte 1 shadow block
module obs_option_shadow_monitor (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        rst_in,
	// load and clock control
	input wire logic        por_load_in,
	input wire logic [7:0]  smr_ctrl_in,
	input wire logic [7:0]  info_addr_out,
	input wire logic        info_rd_out,
	// cpu side
	input wire logic [11:0] reg_addr_in,
	input wire logic        reg_rd_in,
	input wire logic [7:0]  reg_rdata_out,
	input wire logic        reg_rvalid_out,
	// programming gates
	input wire logic        mass_erase_done_in,
	input wire logic        icp_req_in,
	input wire logic        icp_grant_out,
	input wire logic        icp_drop_out,
	input wire logic        bp_req_in,
	input wire logic [1:0]  bp_op_in,
	input wire logic [1:0]  bp_target_in,
	input wire logic        bp_grant_out,
	// clock enable and stack
	input wire logic        sysclk_en_out,
	input wire logic        stack_8bit_out,
	input wire logic [15:0] sp_in,
	input wire logic [15:0] sp_eff_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// a power-on load is only refused while one is already running
	AST_INFO_ADDR: assert property (info_rd_out |-> info_addr_out == 8'hff)
		else $error("info address wrong");
	AST_POR_LOAD: assert property (por_load_in && !info_rd_out
		&& !$past(info_rd_out) |=> info_rd_out) else $error("load not started");
	AST_RD_VALID: assert property (reg_rd_in && reg_addr_in == 12'hd0f
		|=> reg_rvalid_out) else $error("read not answered");
	AST_RSVD_ZERO: assert property (reg_rvalid_out |-> reg_rdata_out[7:4] == 4'h0)
		else $error("reserved bits not zero");
	AST_GATE_ONE: assert property ((icp_grant_out || icp_drop_out) == icp_req_in
		&& !(icp_grant_out && icp_drop_out)) else $error("gate answer wrong");
	AST_PAGE3_RD: assert property (bp_req_in && bp_target_in == 2'b01
		&& bp_op_in == 2'b00 |-> bp_grant_out) else $error("page read blocked");
	AST_ERASE_OPEN: assert property (mass_erase_done_in ##1 bp_req_in
		|-> bp_grant_out) else $error("erase did not open flash");
	AST_SYSCLK_FULL: assert property (smr_ctrl_in[0] && $past(!rst_in)
		|=> sysclk_en_out) else $error("clock enable dropped");
	AST_STACK8: assert property (stack_8bit_out |=> sp_eff_out[15:8] == 8'h00)
		else $error("stack high byte not cleared");
	AST_STACK16: assert property (!stack_8bit_out |=> sp_eff_out == $past(sp_in))
		else $error("stack pointer altered");

	// main scenarios
	COV_ERASE: cover property (mass_erase_done_in);
	COV_LOAD: cover property (info_rd_out);
	COV_DROP: cover property (icp_drop_out);
endmodule : obs_option_shadow_monitor

bind obs_option_shadow obs_option_shadow_monitor u_obs_option_shadow_monitor (
	.clk_in, .rst_in, .por_load_in, .smr_ctrl_in, .info_addr_out, .info_rd_out,
	.reg_addr_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out,
	.mass_erase_done_in, .icp_req_in, .icp_grant_out, .icp_drop_out,
	.bp_req_in, .bp_op_in, .bp_target_in, .bp_grant_out,
	.sysclk_en_out, .stack_8bit_out, .sp_in, .sp_eff_out);

/* File: test/obs_info_model.sv */
`timescale 1ns/1ps
// information block read port: data one cycle after the strobe
module obs_info_model (
	input  wire logic       clk_in,
	input  wire logic       rd_in,
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] stored_in,
	output logic      [7:0] rdata_out
);
	logic [7:0] data_reg = 8'h5a;

	// between reads the port toggles, so a late sample shows up
	always @(posedge clk_in) begin
		if (rd_in && addr_in == 8'hff)
			data_reg <= stored_in | 8'hf0;
		else
			data_reg <= ~data_reg;
	end
	assign rdata_out = data_reg;
endmodule : obs_info_model

/* File: test/option_byte1_shadow_protect_bench.sv */
`timescale 1ns/1ps
module option_byte1_shadow_protect_bench;
	logic        clk_in = 0, rst_in = 1, por_load_in = 0, smr_load_in = 0;
	logic        reg_wr_in = 0, reg_rd_in = 0, mass_erase_done_in = 0;
	logic        icp_req_in = 0, bp_req_in = 0;
	logic [7:0]  smr_ctrl_in = 0, reg_wdata_in = 0, stored = 8'hff;
	logic [11:0] reg_addr_in = 12'hd0f;
	logic [1:0]  icp_op_in = 0, icp_target_in = 0, bp_op_in = 0, bp_target_in = 0;
	logic [13:0] icp_addr_in = 0, bp_addr_in = 0;
	logic [15:0] sp_in = 0, sp_eff_out;
	logic [7:0]  info_addr_out, info_rdata_in, reg_rdata_out;
	logic        info_rd_out, reg_rvalid_out, icp_grant_out, icp_drop_out;
	logic        bp_grant_out, bp_drop_out, sysclk_en_out, stack_8bit_out;
	logic [3:0]  sh;
	logic [7:0]  q[$];
	int          n_mismatch = 0, cmp_count = 0;

	always #2 clk_in = ~clk_in;

	obs_option_shadow #(.MAIN_AW(14)) u_obs_option_shadow (.clk_in, .rst_in,
		.por_load_in, .smr_load_in, .smr_ctrl_in, .info_addr_out, .info_rd_out,
		.info_rdata_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
		.reg_rdata_out, .reg_rvalid_out, .mass_erase_done_in, .icp_req_in,
		.icp_op_in, .icp_target_in, .icp_addr_in, .icp_grant_out, .icp_drop_out,
		.bp_req_in, .bp_op_in, .bp_target_in, .bp_addr_in, .bp_grant_out,
		.bp_drop_out, .sysclk_en_out, .stack_8bit_out, .sp_in, .sp_eff_out);
	obs_info_model u_obs_info_model (.clk_in, .rd_in(info_rd_out),
		.addr_in(info_addr_out), .stored_in(stored), .rdata_out(info_rdata_in));

	task automatic close_out;
		$display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic bad(input string m);
		n_mismatch++;
		$display("MISMATCH %0t %s", $time, m);
	endtask : bad
	task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) bad("shadow read");
	endtask : cmp_rd
	task automatic cmp_gate(input logic g, input logic d, input logic exp);
		cmp_count++;
		if (g !== exp || d !== !exp) bad("gate answer");
	endtask : cmp_gate
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask : cyc
	task automatic rd(input logic [11:0] a, input logic hit);
		reg_addr_in = a;
		reg_rd_in = 1;
		if (hit) q.push_back({4'h0, sh});
		cyc(1);
		reg_rd_in = 0;
		cyc(1);
	endtask : rd
	// protect bits and the reserved nibble are never taken from the cpu
	task automatic wr(input logic [7:0] d);
		reg_addr_in = 12'hd0f;
		reg_wdata_in = d;
		reg_wr_in = 1;
		sh[3:2] = d[3:2];
		cyc(1);
		reg_wr_in = 0;
		cyc(1);
	endtask : wr
	task automatic load(input logic stop_recovery_control, input logic [7:0] ctl, input logic [7:0] b);
		stored = b;
		smr_ctrl_in = ctl;
		if (stop_recovery_control) smr_load_in = 1;
		else por_load_in = 1;
		if (!stop_recovery_control || ctl[5]) sh = b[3:0];
		cyc(1);
		por_load_in = 0;
		smr_load_in = 0;
		cyc(4);
		rd(12'hd0f, 1);
	endtask : load
	// every op, target and address half on both interfaces at once
	task automatic sweep;
		logic e;
		for (int k = 0; k < 18; k++) begin
			icp_op_in = 2'(k % 3);
			icp_target_in = 2'((k / 3) % 3);
			icp_addr_in = {k >= 9, 13'($urandom)};
			{bp_op_in, bp_target_in, bp_addr_in} = {icp_op_in, icp_target_in, icp_addr_in};
			{icp_req_in, bp_req_in} = 2'b11;
			e = k % 9 < 3 ? sh[0] & (sh[1] | k >= 9) : k % 9 < 6 ? k % 3 == 0 | &sh[1:0] : 1;
			#1 cmp_gate(icp_grant_out, icp_drop_out, e);
			cmp_gate(bp_grant_out, bp_drop_out, e);
			cyc(1);
		end
		{icp_req_in, bp_req_in} = 2'b00;
	endtask : sweep
	task automatic clk_cnt(input int exp);
		int c;
		c = 0;
		repeat (20) begin
			cyc(1);
			if (sysclk_en_out === 1'b1) c++;
		end
		cmp_count++;
		if (c != exp) bad("clock enable count");
	endtask : clk_cnt

	// stack pointer traffic keeps both stack widths exercised
	always @(negedge clk_in) sp_in <= 16'($urandom);

	// read answers are matched oldest first against the notes
	always @(negedge clk_in) begin
		if (reg_rvalid_out === 1'b1) begin
			if (q.size() == 0) bad("unexpected read");
			else cmp_rd(reg_rdata_out, q.pop_front());
		end
	end

	// main sequence
	initial begin
		void'($urandom(32'hca6b));
		cyc(5);
		rst_in = 0;
		sh = 4'hc;
		rd(12'hd0f, 1);
		sweep;
		clk_cnt(10);
		load(0, 8'h00, 8'hf2);
		sweep;
		load(0, 8'h00, 8'hf1);
		sweep;
		load(0, 8'h00, 8'hf7);
		sweep;
		wr(8'($urandom) & 8'hf8);
		rd(12'hd0f, 1);
		// the random write is masked with f8h, so it always clears the halving bit
		clk_cnt(sh[2] ? 10 : 20);
		load(1, 8'h01, 8'hf0);
		load(1, 8'h21, 8'hf0);
		smr_ctrl_in = 0;
		sweep;
		mass_erase_done_in = 1;
		sh[1:0] = 2'b11;
		cyc(1);
		mass_erase_done_in = 0;
		sweep;
		rd(12'hd0f, 1);
		rd(12'hd0e, 0);
		rst_in = 1;
		cyc(2);
		rst_in = 0;
		sh = 4'hc;
		rd(12'hd0f, 1);
		cyc(2);
		close_out;
	end

	// the sequence needs about 200 cycles; allow twenty times that
	initial begin
		#16000;
		n_mismatch++;
		close_out;
	end
endmodule : option_byte1_shadow_protect_bench
